// >>> logic/timer_pwm_pkg.sv
// shared constants and types for the two-channel compare and pwm timer
`default_nettype none
package timer_pwm_pkg;

  // ==========================================================================
  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNTER    = 8'h04;
  localparam logic [7:0] OFS_MODULO     = 8'h08;
  localparam logic [7:0] OFS_CH0_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_CH0_CMP    = 8'h10;
  localparam logic [7:0] OFS_CH_STRIDE  = 8'h08;

  // ==========================================================================
  // timer_control_status field positions
  localparam int TC_FLAG    = 7;
  localparam int TC_IRQ_EN  = 6;
  localparam int TC_HALT    = 5;
  localparam int TC_RESET   = 4;
  localparam int TC_PS_LSB  = 0;
  localparam int TC_PS_W    = 3;

  // channel control_status field positions
  localparam int CC_FLAG    = 7;
  localparam int CC_CFG_W   = 7;

  // ==========================================================================
  // reset values and encodings
  localparam logic [15:0] MODULO_RST   = 16'hFFFF;
  localparam logic        HALT_RST     = 1'b1;
  localparam logic [2:0]  PS_EXT       = 3'h7;
  localparam logic [5:0]  DIV_ALL      = 6'h3F;
  localparam logic [1:0]  ACT_TOGGLE   = 2'h1;
  localparam logic [1:0]  ACT_CLEAR    = 2'h2;
  localparam logic [1:0]  ACT_SET      = 2'h3;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic        HRESP_OKAY   = 1'b0;
  localparam int          NUM_CH       = 2;

  // channel control bits in register order, bit 6 down to bit 0
  typedef struct packed {
    logic       irq_en;      // channel_irq_enable
    logic       mode_b;      // upper bit of channel_mode_field; channel_link_select on ch0
    logic       mode_a;      // lower bit of channel_mode_field
    logic [1:0] action;      // compare_action_field
    logic       tov;         // toggle_on_overflow
    logic       full_duty;   // full_duty_select
  } chan_cfg_t;

endpackage
`default_nettype wire

// >>> logic/count_core.sv
// prescaler and 16-bit modulo up-counter
`timescale 1ns/100ps
`default_nettype none
module count_core
  import timer_pwm_pkg::*;
(
  input  wire logic        core_clk,   // bus clock
  input  wire logic        rst_n,      // async reset, active low
  input  wire logic        tclk_pin,   // external timer clock pin
  input  wire logic [2:0]  prescale,   // prescaler select
  input  wire logic        halt,       // counter_halt_bit
  input  wire logic        clear,      // counter reset pulse
  input  wire logic [15:0] modulo,     // period_modulo_value
  output logic      [15:0] count_reg,  // counter value
  output logic             tick,       // counter advance pulse
  output logic             overflow    // counter reached modulo
);

  // ==========================================================================
  // prescaler
  logic [5:0] div_reg;
  logic       tclk_s1_reg;
  logic       tclk_s2_reg;
  logic       tclk_old_reg;
  logic [5:0] div_mask;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tclk_s1_reg  <= 1'b0;
      tclk_s2_reg  <= 1'b0;
      tclk_old_reg <= 1'b0;
    end else begin
      tclk_s1_reg  <= tclk_pin;
      tclk_s2_reg  <= tclk_s1_reg;
      tclk_old_reg <= tclk_s2_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 6'h00;
    end else if (clear) begin
      div_reg <= 6'h00;
    end else if (!halt) begin
      div_reg <= div_reg + 6'h01;
    end
  end

  // low prescale bits all ones marks the end of each divided period
  assign div_mask = ~(DIV_ALL << prescale);
  assign tick     = !halt && !clear && ((prescale == PS_EXT) ? (tclk_s2_reg && !tclk_old_reg)
                                        : ((div_reg & div_mask) == div_mask));
  assign overflow = tick && (count_reg == modulo);

  // ==========================================================================
  // counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
    end else if (clear) begin
      count_reg <= 16'h0000;
    end else if (overflow) begin
      count_reg <= 16'h0000;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// >>> logic/compare_unit.sv
// one output compare channel: match detect and pin drive
`timescale 1ns/100ps
`default_nettype none
module compare_unit
  import timer_pwm_pkg::*;
(
  input  wire logic        core_clk,   // bus clock
  input  wire logic        rst_n,      // async reset, active low
  input  wire logic        enable,     // channel is in compare mode
  input  wire logic        tick,       // counter advance pulse
  input  wire logic        overflow,   // counter overflow pulse
  input  wire logic [15:0] count,      // counter value
  input  wire logic [15:0] cmp_value,  // compare value in control
  input  wire chan_cfg_t   cfg,        // channel configuration
  output logic             match,      // compare match pulse
  output logic             pin_reg     // channel pin level
);

  logic pin_next;

  // match as the counter arrives at the value, so the pulse after the
  // overflow toggle lasts exactly cmp_value ticks
  assign match = enable && tick
                 && (cmp_value == (overflow ? 16'h0000 : count + 16'h0001));

  // ==========================================================================
  // pin action; overflow toggle is applied after the compare action
  always_comb begin
    pin_next = pin_reg;
    if (cfg.full_duty && cfg.tov) begin
      pin_next = (cfg.action != ACT_SET);
    end else begin
      if (match) begin
        unique case (cfg.action)
          ACT_TOGGLE: pin_next = ~pin_reg;
          ACT_CLEAR:  pin_next = 1'b0;
          ACT_SET:    pin_next = 1'b1;
          default:    pin_next = pin_reg;
        endcase
      end
      if (overflow && cfg.tov) begin
        pin_next = ~pin_next;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= 1'b0;
    end else if (enable) begin
      pin_reg <= pin_next;
    end
  end

endmodule
`default_nettype wire

// >>> logic/timer_pwm.sv
// two-channel timer output side: buffered compare and pwm with ahb-lite registers
//
// Contract
// - link bit joins channels 0 and 1 onto channel0 pin, channel 0 first
// - channel 1 write takes control at next overflow; last written pair thereafter
// - linked: channel 0 control governs and reports; channel 1 control ignored
// - linked: channel1 pin released to general-purpose use
// - toggle-on-overflow toggles the pin each time counter reaches modulo
// - modulo 255, prescale 0 gives a 256-clock period
// - compare 128 with modulo 255 gives half-period pulse
// - compare interrupt at pulse end, overflow interrupt at period end
// - buffered: channel 1 width applies from next period; mid-period only when channel 1 pair is already active
// - mode field 01 unbuffered, 10 buffered
// - action field 10 clears, 11 sets on compare
// - link bit overrides channel 0 lower mode bit
// - toggle-on-overflow clear: no overflow toggle, zero duty
// - full duty bit plus toggle-on-overflow holds full duty
// - overflow flag sets at modulo; interrupt only when enabled
// - channel flag sets on match; interrupt only when enabled
// - overflow flag cleared by read-then-write-zero; new overflow keeps it
// - counter reset bit clears counter and prescaler, reads zero
`timescale 1ns/100ps
`default_nettype none
module timer_pwm
  import timer_pwm_pkg::*;
(
  input  wire logic        core_clk,       // bus clock, 40 MHz
  input  wire logic        rst_n,          // async reset, active low
  input  wire logic        hsel,           // ahb slave select
  input  wire logic [7:0]  haddr,          // ahb byte address
  input  wire logic [1:0]  htrans,         // ahb transfer type
  input  wire logic        hwrite,         // ahb write
  input  wire logic [2:0]  hsize,          // ahb size, word only
  input  wire logic [31:0] hwdata,         // ahb write data
  input  wire logic        hready,         // ahb bus ready
  output logic             hreadyout,      // ahb slave ready
  output logic      [31:0] hrdata,         // ahb read data
  output logic             hresp,          // ahb response
  input  wire logic        tclk_pin,       // external timer clock pin
  output logic             ch0_pin_out,    // channel0_pin level
  output logic             ch0_pin_oe_n,   // channel0_pin enable, low drives
  output logic             ch1_pin_out,    // channel1_pin level
  output logic             ch1_pin_oe_n,   // channel1_pin enable, low drives
  output logic             ch1_gpio_release, // channel1_pin free for port use
  output logic             overflow_irq,   // overflow interrupt request
  output logic             ch0_irq,        // channel 0 interrupt request
  output logic             ch1_irq         // channel 1 interrupt request
);

  // ==========================================================================
  // ahb-lite slave: zero wait, read data registered at the address phase
  logic        addr_take;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic        wr_ctrl;

  assign addr_take = hsel && hready && (htrans == HTRANS_NSEQ);
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = rd_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_take && hwrite;
      wr_addr_reg <= haddr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      rd_reg <= rd_next;
    end
  end

  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == OFS_TIMER_CTRL);

  // ==========================================================================
  // timer control and modulo
  logic        ovf_flag_reg;
  logic        ovf_armed_reg;
  logic        ovf_irq_en_reg;
  logic        halt_reg;
  logic [2:0]  prescale_reg;
  logic [15:0] modulo_reg;
  logic        count_clear;
  logic [15:0] count_q;
  logic        tick;
  logic        overflow;

  assign count_clear = wr_ctrl && hwdata[TC_RESET];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_irq_en_reg <= 1'b0;
      halt_reg       <= HALT_RST;
      prescale_reg   <= 3'h0;
    end else if (wr_ctrl) begin
      ovf_irq_en_reg <= hwdata[TC_IRQ_EN];
      halt_reg       <= hwdata[TC_HALT];
      prescale_reg   <= hwdata[TC_PS_LSB +: TC_PS_W];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      modulo_reg <= MODULO_RST;
    end else if (wr_pend_reg && (wr_addr_reg == OFS_MODULO)) begin
      modulo_reg <= hwdata[15:0];
    end
  end

  // a read arms the clear; an overflow disarms it so a late zero write is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_reg  <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else begin
      if (overflow) begin
        ovf_flag_reg  <= 1'b1;
        ovf_armed_reg <= 1'b0;
      end else if (wr_ctrl && ovf_armed_reg && !hwdata[TC_FLAG]) begin
        ovf_flag_reg  <= 1'b0;
        ovf_armed_reg <= 1'b0;
      end else if (addr_take && !hwrite && haddr == OFS_TIMER_CTRL && ovf_flag_reg) begin
        ovf_armed_reg <= 1'b1;
      end
    end
  end

  assign overflow_irq = ovf_flag_reg && ovf_irq_en_reg;

  count_core u_count (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .tclk_pin  (tclk_pin),
    .prescale  (prescale_reg),
    .halt      (halt_reg),
    .clear     (count_clear),
    .modulo    (modulo_reg),
    .count_reg (count_q),
    .tick      (tick),
    .overflow  (overflow)
  );

  // ==========================================================================
  // channel registers, flags and compare units
  chan_cfg_t   cfg_reg   [NUM_CH];
  logic [15:0] cmp_reg   [NUM_CH];
  logic        flag_reg  [NUM_CH];
  logic        armed_reg [NUM_CH];
  logic        ch_en     [NUM_CH];
  logic        match     [NUM_CH];
  logic        pin_q     [NUM_CH];
  logic [15:0] cmp_use   [NUM_CH];
  logic        link;
  logic        active_sel_reg;
  logic        pending_sel_reg;

  // link bit on channel 0 outranks its lower mode bit
  assign link     = cfg_reg[0].mode_b;
  assign ch_en[0] = link || (cfg_reg[0].mode_a && !cfg_reg[0].mode_b);
  assign ch_en[1] = !link && (cfg_reg[1].mode_a || cfg_reg[1].mode_b);
  assign cmp_use[0] = (link && active_sel_reg) ? cmp_reg[1] : cmp_reg[0];
  assign cmp_use[1] = cmp_reg[1];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      localparam logic [7:0] OFS_CTRL = 8'(OFS_CH0_CTRL + gi * OFS_CH_STRIDE);
      localparam logic [7:0] OFS_CMP  = 8'(OFS_CH0_CMP + gi * OFS_CH_STRIDE);
      logic wr_cc;

      assign wr_cc = wr_pend_reg && (wr_addr_reg == OFS_CTRL);

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_reg[gi] <= '0;
        end else if (wr_cc) begin
          cfg_reg[gi] <= hwdata[CC_CFG_W-1:0];
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cmp_reg[gi] <= 16'h0000;
        end else if (wr_pend_reg && (wr_addr_reg == OFS_CMP)) begin
          cmp_reg[gi] <= hwdata[15:0];
        end
      end

      // same read-then-write-zero clear as the overflow flag; set wins
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          flag_reg[gi]  <= 1'b0;
          armed_reg[gi] <= 1'b0;
        end else begin
          if (match[gi]) begin
            flag_reg[gi]  <= 1'b1;
            armed_reg[gi] <= 1'b0;
          end else if (wr_cc && armed_reg[gi] && !hwdata[CC_FLAG]) begin
            flag_reg[gi]  <= 1'b0;
            armed_reg[gi] <= 1'b0;
          end else if (addr_take && !hwrite && haddr == OFS_CTRL && flag_reg[gi]) begin
            armed_reg[gi] <= 1'b1;
          end
        end
      end

      compare_unit u_cmp (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .enable    (ch_en[gi]),
        .tick      (tick),
        .overflow  (overflow),
        .count     (count_q),
        .cmp_value (cmp_use[gi]),
        .cfg       (cfg_reg[gi]),
        .match     (match[gi]),
        .pin_reg   (pin_q[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // buffered pair selector: swaps only on overflow, so width changes land on
  // period boundaries; writing the active pair is seen at once, as unbuffered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_sel_reg  <= 1'b0;
      pending_sel_reg <= 1'b0;
    end else if (!link) begin
      active_sel_reg  <= 1'b0;
      pending_sel_reg <= 1'b0;
    end else begin
      if (wr_pend_reg && wr_addr_reg == OFS_CH0_CMP + OFS_CH_STRIDE) begin
        pending_sel_reg <= 1'b1;
      end else if (wr_pend_reg && wr_addr_reg == OFS_CH0_CMP) begin
        pending_sel_reg <= 1'b0;
      end
      if (overflow) begin
        active_sel_reg <= pending_sel_reg;
      end
    end
  end

  // ==========================================================================
  // pins and interrupt requests
  assign ch0_pin_out      = pin_q[0];
  assign ch0_pin_oe_n     = !ch_en[0];
  assign ch1_pin_out      = pin_q[1];
  assign ch1_pin_oe_n     = !ch_en[1];
  assign ch1_gpio_release = link;
  assign ch0_irq          = flag_reg[0] && cfg_reg[0].irq_en;
  assign ch1_irq          = flag_reg[1] && cfg_reg[1].irq_en && !link;

  // ==========================================================================
  // read mux; reset bit and bit 3 read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (haddr)
      OFS_TIMER_CTRL: rd_next[7:0] = {ovf_flag_reg, ovf_irq_en_reg, halt_reg, 2'h0,
                                      prescale_reg};
      OFS_COUNTER:    rd_next[15:0] = count_q;
      OFS_MODULO:     rd_next[15:0] = modulo_reg;
      OFS_CH0_CTRL:   rd_next[7:0] = {flag_reg[0], cfg_reg[0]};
      OFS_CH0_CMP:    rd_next[15:0] = cmp_reg[0];
      OFS_CH0_CTRL + OFS_CH_STRIDE: rd_next[7:0] = {flag_reg[1], cfg_reg[1]};
      OFS_CH0_CMP + OFS_CH_STRIDE:  rd_next[15:0] = cmp_reg[1];
      default:        rd_next = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_PERIOD_WRAP: assert property (
    overflow && !count_clear |=> count_q == 16'h0000)
    else $error("counter did not restart after reaching modulo");

  AST_OVF_FLAG: assert property (
    overflow |=> ovf_flag_reg ##0 overflow_irq == ovf_irq_en_reg)
    else $error("overflow flag or request wrong after overflow");

  AST_CH_FLAG: assert property (
    match[0] |=> flag_reg[0] && (ch0_irq == cfg_reg[0].irq_en))
    else $error("channel 0 flag not set on match");

  AST_CH1_RELEASE: assert property (
    link |-> ch1_pin_oe_n && ch1_gpio_release && !match[1] && !ch1_irq)
    else $error("channel 1 pin still owned while linked");

  AST_SEL_START: assert property (
    $rose(link) |-> !active_sel_reg)
    else $error("linked pair did not start on channel 0");

  AST_SEL_HOLD: assert property (
    link && !overflow && $past(link) |=> active_sel_reg == $past(active_sel_reg))
    else $error("active pair changed away from an overflow");

  AST_SEL_SWAP: assert property (
    link && overflow && pending_sel_reg |=> active_sel_reg || !link)
    else $error("written channel 1 pair did not take over at overflow");

  AST_ZERO_DUTY: assert property (
    ch_en[0] && !cfg_reg[0].tov && !match[0] && !wr_pend_reg |=> $stable(ch0_pin_out))
    else $error("pin moved without a compare while overflow toggle off");

  AST_TOGGLE: assert property (
    ch_en[0] && cfg_reg[0].tov && !cfg_reg[0].full_duty && overflow && !match[0]
      && !wr_pend_reg |=> ch0_pin_out != $past(ch0_pin_out))
    else $error("pin did not toggle on overflow");

  AST_FULL_DUTY: assert property (
    ch_en[0] && cfg_reg[0].tov && cfg_reg[0].full_duty && !wr_pend_reg
      |=> ch0_pin_out == (cfg_reg[0].action != ACT_SET))
    else $error("full duty output not held at pulse level");

  AST_CNT_RESET: assert property (
    count_clear |=> count_q == 16'h0000 ##1 count_q <= 16'h0001)
    else $error("counter reset bit did not clear the counter");

endmodule
`default_nettype wire

// >>> test/pwm_load.sv
// load model on channel0_pin: measures high time and period
`timescale 1ns/100ps
`default_nettype none
module pwm_load (
  input  wire logic        core_clk, // bus clock
  input  wire logic        pin,      // channel0_pin level
  input  wire logic        arm,      // report the period that ends next
  output logic             rise,     // pin rose since last edge
  output logic             valid,    // measurement ready
  output logic      [15:0] hi_cnt,   // cycles high in period
  output logic      [15:0] per_cnt   // cycles in period
);
  logic        pin_d;
  logic [15:0] hi;
  logic [15:0] per;
  assign rise = pin & ~pin_d;
  // period runs rise to rise, so a stuck pin never reports
  always_ff @(posedge core_clk) begin
    pin_d <= pin;
    valid <= rise & arm;
    if (rise) begin
      hi_cnt  <= hi;
      per_cnt <= per;
      hi      <= 16'h0001;
      per     <= 16'h0001;
    end else begin
      hi  <= hi + {15'h0000, pin};
      per <= per + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> test/timer_pwm_tb.sv
// self-checking bench for the two-channel compare and pwm timer
`timescale 1ns/100ps
`default_nettype none
module timer_pwm_tb;
  import timer_pwm_pkg::*;
  localparam logic [7:0]  CH1_CTRL = OFS_CH0_CTRL + OFS_CH_STRIDE;
  localparam logic [7:0]  CH1_CMP  = OFS_CH0_CMP + OFS_CH_STRIDE;
  localparam logic [15:0] MOD      = 16'h00FF;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic arm = 1'b0;
  logic rd_phase = 1'b0;
  wire logic hreadyout, hresp, ch0_pin_out, ch0_pin_oe_n, ch1_pin_out, ch1_pin_oe_n;
  wire logic ch1_gpio_release, overflow_irq, ch0_irq, ch1_irq, rise, valid;
  wire logic [31:0] hrdata;
  wire logic [15:0] hi_cnt, per_cnt;
  logic [31:0] rd_q[$];
  logic [31:0] pw_q[$];
  integer bad_count = 0;
  integer comparisons = 0;
  integer seed = 50923;
  integer i;
  logic [15:0] w;
  always #12.5 core_clk = ~core_clk;
  timer_pwm dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tclk_pin(1'b0),
    .ch0_pin_out(ch0_pin_out), .ch0_pin_oe_n(ch0_pin_oe_n), .ch1_pin_out(ch1_pin_out),
    .ch1_pin_oe_n(ch1_pin_oe_n), .ch1_gpio_release(ch1_gpio_release),
    .overflow_irq(overflow_irq), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq));
  pwm_load load (.core_clk(core_clk), .pin(ch0_pin_out), .arm(arm), .rise(rise),
    .valid(valid), .hi_cnt(hi_cnt), .per_cnt(per_cnt));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_ready;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  // read expectations go to the watcher, which takes hrdata at data-phase end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NSEQ;
    hwrite <= wr;
    haddr <= a;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= ~wr;
    if (!wr) rd_q.push_back(d);
    wait_ready;
    rd_phase <= 1'b0;
  endtask
  task automatic wait_rise;
    do @(negedge core_clk); while (rise !== 1'b1);
  endtask
  // optional write just after an overflow, then measure the following period
  task automatic pwm(input logic [15:0] hi, input logic wr, input logic [7:0] a,
                     input logic [15:0] d);
    wait_rise;
    if (wr) bus(1'b1, a, {16'h0000, d});
    @(posedge core_clk);
    arm <= 1'b1;
    pw_q.push_back({hi, MOD + 16'h0001});
    wait_rise;
    @(posedge core_clk);
    arm <= 1'b0;
  endtask
  always @(posedge core_clk) begin
    if (rd_phase) check(hrdata, rd_q.pop_front());
    if (valid) check({hi_cnt, per_cnt}, pw_q.pop_front());
  end
  initial begin
    #(25 * 40000);
    bad_count = bad_count + 1;
    stop_test;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b0, OFS_TIMER_CTRL, 32'h20);
    bus(1'b0, OFS_MODULO, 32'hFFFF);
    bus(1'b0, 8'hFC, 32'h0);
    bus(1'b1, OFS_TIMER_CTRL, 32'h30); // halt with counter reset
    bus(1'b0, OFS_TIMER_CTRL, 32'h20);
    bus(1'b0, OFS_COUNTER, 32'h0);
    bus(1'b1, OFS_MODULO, {16'h0000, MOD});
    bus(1'b1, OFS_CH0_CMP, 32'h80);
    bus(1'b1, OFS_CH0_CTRL, 32'h1A); // high pulse: clear on compare
    bus(1'b1, OFS_TIMER_CTRL, 32'h00);
    pwm(16'h0080, 1'b0, 8'h00, 16'h0);
    wait_rise;
    bus(1'b0, OFS_TIMER_CTRL, 32'h80);
    bus(1'b0, OFS_CH0_CTRL, 32'h9A);
    bus(1'b1, OFS_TIMER_CTRL, 32'h40);
    bus(1'b1, OFS_CH0_CTRL, 32'h5A);
    bus(1'b0, OFS_TIMER_CTRL, 32'h40);
    check(overflow_irq, 1'b0);
    wait_rise;
    check(overflow_irq, 1'b1);
    check(ch0_irq, 1'b1);
    bus(1'b0, OFS_TIMER_CTRL, 32'hC0);
    wait_rise;
    bus(1'b1, OFS_TIMER_CTRL, 32'h40); // overflow after the read, flag must stay
    bus(1'b0, OFS_TIMER_CTRL, 32'hC0);
    wait_rise;
    bus(1'b1, OFS_CH0_CTRL, 32'h18);
    for (i = 0; i < 4; i++) begin
      repeat (150) @(negedge core_clk);
      check(ch0_pin_out, 1'b0);
    end
    bus(1'b1, OFS_CH0_CTRL, 32'h1B);
    repeat (300) @(negedge core_clk);
    for (i = 0; i < 4; i++) begin
      repeat (100) @(negedge core_clk);
      check(ch0_pin_out, 1'b1);
    end
    // lower mode bit also set: link must still win
    bus(1'b1, OFS_CH0_CTRL, 32'h3A);
    bus(1'b1, CH1_CTRL, 32'h5A);
    check(ch1_gpio_release, 1'b1);
    check(ch1_pin_oe_n, 1'b1);
    check(ch0_pin_oe_n, 1'b0);
    pwm(16'h0080, 1'b0, 8'h00, 16'h0);
    w = 16'h0010 + 16'($random(seed) & 32'h7F);
    pwm(16'h0080, 1'b1, CH1_CMP, w); // inactive pair only
    pwm(w, 1'b0, 8'h00, 16'h0);
    pwm(w, 1'b1, OFS_CH0_CMP, 16'h0030);
    pwm(16'h0030, 1'b0, 8'h00, 16'h0);
    check(ch1_irq, 1'b0);
    check(hresp, HRESP_OKAY);
    // unlinked again: channel 1 owns its pin, longer width written after overflow
    bus(1'b1, OFS_CH0_CTRL, 32'h1A);
    pwm(16'h00A0, 1'b1, OFS_CH0_CMP, 16'h00A0);
    check(ch1_pin_oe_n, 1'b0);
    check(ch1_pin_out, 1'b1);
    stop_test;
  end
endmodule
`default_nettype wire
